/* sim/event_source_model.sv */
`timescale 1ns/1ps
// Sources move only on clock edges, like the on-chip timers and serial port
module event_source_model (
  input  wire logic        clk_i,
  input  wire logic [19:0] rnd_i,
  output logic      [19:0] src_o
);
  always_ff @(posedge clk_i) src_o <= rnd_i;
endmodule  // event_source_model

/* sim/sop_checker_sva.sv */
`timescale 1ns/1ps
module sop_checker (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        divided_zero_crossing_i,
  input wire logic        timer0_channel0_out_i,
  input wire logic        timer0_channel1_out_i,
  input wire logic        serial_transmit_line_i,
  input wire logic        event_function_output_o
);
  logic [31:0] cfg_reg, sel_reg;
  wire  [3:0]  ev_in = {serial_transmit_line_i, timer0_channel1_out_i, timer0_channel0_out_i,
                        divided_zero_crossing_i};
  // Shadow of software writes, so read-back and output are judged against intent
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) {cfg_reg, sel_reg} <= 64'h0;
    else if (wr_i && addr_i == 8'h00) cfg_reg <= wdata_i;
    else if (wr_i && addr_i == 8'h04) sel_reg <= wdata_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  evt_func_a: assert property (event_function_output_o ==
    sop_ref_pkg::ev_f(cfg_reg, ev_in)) else $error("event wrong");
  zero_cfg_a: assert property (cfg_reg == 32'h0 |-> !event_function_output_o)
    else $error("event high");
  cfg_rd_a: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == $past(cfg_reg))
    else $error("config read");
  sel_rd_a: assert property (rd_i && addr_i == 8'h04 |=> rdata_o == $past(sel_reg))
    else $error("select read");
  stat_rd_a: assert property (rd_i && addr_i == 8'h08 |=>
    rdata_o == {27'h0, $past(event_function_output_o), $past(ev_in)}) else $error("status");
  hole_rd_a: assert property (rd_i && addr_i > 8'h08 |=> rdata_o == 32'h0)
    else $error("unmapped read");
  idle_rd_a: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("stale read");
  wr_rd_a: assert property (wr_i && addr_i == 8'h00 ##1 !wr_i ##1 rd_i && addr_i == 8'h00
    |=> rdata_o == $past(wdata_i, 3)) else $error("write lost");
  cover property (event_function_output_o);
  cover property (rd_i && addr_i == 8'h08);
  cover property (wr_i && addr_i == 8'h04);
endmodule  // sop_checker
bind sum_of_products_unit sop_checker u_chk (.*);

/* sim/sop_ref_pkg.sv */
package sop_ref_pkg;
  function automatic logic ev_f(logic [31:0] c, logic [3:0] v);
    logic [3:0] f = 4'hF;
    for (int p = 0; p < 4; p++)
      for (int i = 0; i < 4; i++)
        f[p] &= 1'({1'b1, ~v[i], v[i], 1'b0} >> c[31-8*p-2*i -: 2]);
    return |f;
  endfunction
endpackage

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, ev_o, e = 1'b0;
  logic [7:0]  addr_i = 8'h00, xb;
  logic [19:0] rnd = 20'h0, src;
  logic [31:0] wdata_i = 32'h0, rdata_o, cfg = 32'h0, sel = 32'h0;
  int          seed = 32'h9CCFFFD7, n_fail = 0, checked = 0;
  initial forever #5 clk_i = ~clk_i;
  event_source_model u_src (.clk_i, .rnd_i(rnd), .src_o(src));
  sum_of_products_unit u_dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .divided_zero_crossing_i(src[0]), .timer0_channel0_out_i(src[1]),
    .timer0_channel1_out_i(src[2]), .serial_transmit_line_i(src[3]),
    .xbar_source_i(src[19:4]), .event_function_output_o(ev_o), .xbar_out_o(xb));
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    checked++;
    if (g !== x) n_fail++;
    if (g !== x) $display("BAD %s exp %h got %h", n, x, g);
  endtask
  // Every crossbar output against its select field; fixed sources override the spare inputs
  function automatic logic [7:0] xb_exp(logic [31:0] s, logic ev, logic [19:0] r);
    logic [7:0]  x;
    logic [15:0] v;
    v = {r[19:13], r[3], r[2], r[1], ev, r[0], r[7], 1'h1, 2'h0};
    for (int o = 0; o < 8; o++)
      x[o] = v[s[4*o +: 4]];
    return x;
  endfunction
  // Read data stand only in the cycle after the strobe, so look mid-cycle there
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    {wr_i, rd_i, addr_i, wdata_i} <= {w, !w, a, d};
    @(posedge clk_i) {wr_i, rd_i} <= 2'h0;
    @(negedge clk_i) if (!w) chk("rdata", d, rdata_o);
    @(posedge clk_i);
  endtask
  task automatic step();
    rnd <= 20'($random(seed));
    @(posedge clk_i);
    @(negedge clk_i) e = sop_ref_pkg::ev_f(cfg, src[3:0]);
    chk("event", 32'(e), 32'(ev_o));
    chk("xbar", 32'(e), 32'(xb[0]));
    chk("xbar_all", 32'(xb_exp(sel, e, src)), 32'(xb));
    @(posedge clk_i);
  endtask
  task automatic results();
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000 n_fail++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    bus(0, 8'h00, 32'h0);
    step();
    for (int k = 0; k < 100; k++) begin
      cfg = k == 0 ? 32'h7FDFF7FD : $random(seed);
      sel = {28'($random(seed)), 4'h5};
      bus(1, 8'h00, cfg);
      bus(0, 8'h00, cfg);
      bus(1, 8'h04, sel);
      repeat (4) step();
      bus(0, 8'h04, sel);
      bus(0, 8'h08, {27'h0, e, src[3:0]});
      bus(0, 8'h0C + 8'(k), 32'h0);
    end
    results();
  end
endmodule  // tb

/* src/event_function_pkg.sv */
package event_function_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam int          ADDR_W             = 8;
  localparam int          DATA_W             = 32;
  localparam logic [7:0]  CONFIG_OFFSET      = 8'h00;
  localparam logic [7:0]  XBAR_SELECT_OFFSET = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET      = 8'h08;
  localparam logic [31:0] CONFIG_RESET       = 32'h0000_0000;
  localparam logic [31:0] XBAR_SELECT_RESET  = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

  // ********************************************************************
  // Product term layout
  // ********************************************************************
  localparam int NUM_TERMS     = 4;
  localparam int NUM_INPUTS    = 4;
  localparam int SEL_W         = 2;
  localparam int TERM_W        = NUM_INPUTS * SEL_W;
  localparam int CONFIG_TOP    = 31;
  localparam int INPUT_A       = 0;
  localparam int INPUT_B       = 1;
  localparam int INPUT_C       = 2;
  localparam int INPUT_D       = 3;

  // Selector encoding of one factor
  localparam logic [1:0] SEL_ZERO   = 2'h0;
  localparam logic [1:0] SEL_TRUE   = 2'h1;
  localparam logic [1:0] SEL_INVERT = 2'h2;
  localparam logic [1:0] SEL_ONE    = 2'h3;

  // ********************************************************************
  // Signal crossbar
  // ********************************************************************
  localparam int         XBAR_SEL_W       = 4;
  localparam int         XBAR_NUM_SRC     = 16;
  localparam int         XBAR_NUM_OUT     = 8;
  localparam logic [3:0] SRC_NONE         = 4'h0;
  localparam logic [3:0] SRC_GROUND       = 4'h1;
  localparam logic [3:0] SRC_SUPPLY       = 4'h2;
  localparam logic [3:0] SRC_DIV_ZC       = 4'h4;
  localparam logic [3:0] SRC_EVENT_OUT    = 4'h5;
  localparam logic [3:0] SRC_TIMER0_CH0   = 4'h6;
  localparam logic [3:0] SRC_TIMER0_CH1   = 4'h7;
  localparam logic [3:0] SRC_SERIAL_TX    = 4'h8;

  // Status bit positions
  localparam int STAT_EVENT_BIT = 4;

endpackage

/* src/sum_of_products_unit.sv */
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module sum_of_products_unit #(
  parameter int NUM_XBAR_OUT = event_function_pkg::XBAR_NUM_OUT
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic [7:0]              addr_i,
  input  wire logic [31:0]             wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [31:0]             rdata_o,
  input  wire logic                    divided_zero_crossing_i,
  input  wire logic                    timer0_channel0_out_i,
  input  wire logic                    timer0_channel1_out_i,
  input  wire logic                    serial_transmit_line_i,
  input  wire logic [15:0]             xbar_source_i,
  output logic                         event_function_output_o,
  output logic [NUM_XBAR_OUT-1:0]      xbar_out_o
);

  // ********************************************************************
  // Event inputs
  // ********************************************************************
  // Not synchronised: these come from on-chip logic and the trigger path
  // must stay combinational end to end.
  logic [3:0] event_in;
  assign event_in[event_function_pkg::INPUT_A] = divided_zero_crossing_i;
  assign event_in[event_function_pkg::INPUT_B] = timer0_channel0_out_i;
  assign event_in[event_function_pkg::INPUT_C] = timer0_channel1_out_i;
  assign event_in[event_function_pkg::INPUT_D] = serial_transmit_line_i;

  // ********************************************************************
  // Registers
  // ********************************************************************
  logic [31:0] event_function_config_reg;
  logic [31:0] event_function_config_next;
  logic [31:0] xbar_select_reg;
  logic [31:0] xbar_select_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        event_out;

  always_comb begin
    event_function_config_next = event_function_config_reg;
    xbar_select_next           = xbar_select_reg;
    rdata_next                 = event_function_pkg::READ_ZERO;
    if (wr_i) begin
      unique case (addr_i)
        event_function_pkg::CONFIG_OFFSET: begin
          event_function_config_next = wdata_i;
        end
        event_function_pkg::XBAR_SELECT_OFFSET: begin
          xbar_select_next = wdata_i;
        end
        default: begin
        end
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        event_function_pkg::CONFIG_OFFSET: begin
          rdata_next = event_function_config_reg;
        end
        event_function_pkg::XBAR_SELECT_OFFSET: begin
          rdata_next = xbar_select_reg;
        end
        event_function_pkg::STATUS_OFFSET: begin
          rdata_next = {27'h0000000, event_out, event_in};
        end
        default: begin
          rdata_next = event_function_pkg::READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_function_config_reg <= event_function_pkg::CONFIG_RESET;
      xbar_select_reg           <= event_function_pkg::XBAR_SELECT_RESET;
      rdata_reg                 <= event_function_pkg::READ_ZERO;
    end else begin
      event_function_config_reg <= event_function_config_next;
      xbar_select_reg           <= xbar_select_next;
      rdata_reg                 <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  // ********************************************************************
  // Sum of products
  // ********************************************************************
  function automatic logic factor(input logic [1:0] sel, input logic x);
    logic f;
    f = 1'b0;
    unique case (sel)
      event_function_pkg::SEL_ZERO:   f = 1'b0;
      event_function_pkg::SEL_TRUE:   f = x;
      event_function_pkg::SEL_INVERT: f = ~x;
      event_function_pkg::SEL_ONE:    f = 1'b1;
    endcase
    return f;
  endfunction

  logic [3:0] term;
  logic [3:0] fac [4];

  for (genvar t = 0; t < event_function_pkg::NUM_TERMS; t++) begin : g_term
    for (genvar i = 0; i < event_function_pkg::NUM_INPUTS; i++) begin : g_in
      // Term 0 in the top byte, input A in the top pair of each byte
      localparam int HI = event_function_pkg::CONFIG_TOP
                          - t * event_function_pkg::TERM_W
                          - i * event_function_pkg::SEL_W;
      assign fac[t][i] = factor(event_function_config_reg[HI -: event_function_pkg::SEL_W],
                                event_in[i]);
    end
    assign term[t] = &fac[t];
  end

  // No register on this path: it is used as a hardware trigger
  assign event_out               = |term;
  assign event_function_output_o = event_out;

  // ********************************************************************
  // Signal crossbar
  // ********************************************************************
  logic [15:0] xbar_src;
  always_comb begin
    xbar_src                                     = xbar_source_i;
    xbar_src[event_function_pkg::SRC_NONE]       = 1'b0;
    xbar_src[event_function_pkg::SRC_GROUND]     = 1'b0;
    xbar_src[event_function_pkg::SRC_SUPPLY]     = 1'b1;
    xbar_src[event_function_pkg::SRC_DIV_ZC]     = divided_zero_crossing_i;
    xbar_src[event_function_pkg::SRC_EVENT_OUT]  = event_out;
    xbar_src[event_function_pkg::SRC_TIMER0_CH0] = timer0_channel0_out_i;
    xbar_src[event_function_pkg::SRC_TIMER0_CH1] = timer0_channel1_out_i;
    xbar_src[event_function_pkg::SRC_SERIAL_TX]  = serial_transmit_line_i;
  end

  // Also combinational so a trigger routed through keeps zero latency
  for (genvar o = 0; o < NUM_XBAR_OUT; o++) begin : g_xbar
    assign xbar_out_o[o] = xbar_src[xbar_select_reg[o*event_function_pkg::XBAR_SEL_W
                                                    +: event_function_pkg::XBAR_SEL_W]];
  end

endmodule // sum_of_products_unit
